/* rbac_monitor.sv */
// Checker for the register bit cell bank
`timescale 1ns/1ps
module rbac_monitor
  import rbac_pkg::*;
(
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hard_rst_n_i,
  // Read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  // Hardware side
  input wire rbac_hw_t hw_i,
  input wire rbac_cells_t cells_o
);
  // Either reset silences every check
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || !hard_rst_n_i);
  a_rc_set_lands: assert property (|hw_i.rc_set |=> (cells_o.rc & $past(hw_i.rc_set)) == $past(hw_i.rc_set))
    else $error("read-clear event lost");
  a_rc_read_clears: assert property (s_axi_arvalid_i && s_axi_arready_o
    && (s_axi_araddr_i & WORD_MASK) == OFS_RC && hw_i.rc_set == 8'h00 |=> cells_o.rc == 8'h00)
    else $error("read-clear cell kept after read");
  // Every event bit must land, not just one of them
  a_w1cs_set_lands: assert property (|hw_i.w1cs_set
    |=> (cells_o.w1cs & $past(hw_i.w1cs_set)) == $past(hw_i.w1cs_set))
    else $error("sticky clear-flag event lost");
  a_readable_set_only_cell_hw_clear: assert property (|hw_i.readable_set_only_cell_clr |=> (cells_o.readable_set_only_cell & $past(hw_i.readable_set_only_cell_clr)) == 8'h00)
    else $error("set-only bit not cleared by hardware");
  // Software alone may never take a set-only bit back to zero
  a_readable_set_only_cell_no_swclr: assert property ((~cells_o.readable_set_only_cell & $past(cells_o.readable_set_only_cell) & ~$past(hw_i.readable_set_only_cell_clr)) == 8'h00)
    else $error("set-only bit fell without hardware clear");
  a_ros_capture: assert property (hw_i.ros_load |=> cells_o.sticky_readonly_cell == $past(hw_i.ros_val))
    else $error("sticky status not captured");
  a_force_write: assert property (hw_i.force_we |=> cells_o.rofw == $past(hw_i.force_val))
    else $error("forced write not applied");
  a_rwv_hw_update: assert property (hw_i.rwv_we |=> cells_o.rwv == $past(hw_i.rwv_val))
    else $error("hardware update of volatile cell lost");
endmodule : rbac_monitor

bind rbac_top rbac_monitor mon (.clk_i, .rst_n_i, .hard_rst_n_i, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .hw_i, .cells_o);

/* rbac_pkg.sv */
// Package holding the constants, offsets and carrier types of the register bit cell bank
package rbac_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;  // Byte address width of the register window
  localparam int DATA_W = 32;  // AXI4-Lite data width
  localparam int STRB_W = DATA_W / 8;  // Byte lanes
  localparam int CELL_W = 8;  // Implemented bits per register, rest read zero
  localparam int BYP_N = 4;  // Number of lock-bypass source groups

  // Response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // Request source decode from the protection field
  localparam int PROT_PRIV_BIT = 0;  // Set: microcode or forced-write agent, clear: core
  localparam int GRP_LSB = 0;  // Source group taken from prot[1:0]
  localparam int GRP_W = 2;

  // Lock source field layout
  localparam int LOCK_BIT = 0;  // Bit of the lock source cell that locks other fields

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_RO = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RW = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_W1S = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_WO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RWO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LOCK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_BYPEN = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_RWL = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_W1C = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_W0C = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_ROS = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_READABLE_SET_ONLY_CELL = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_RWS = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_W1CS = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_RWLB = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_ROFW = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_RWSO = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_RWV = 8'h48;
  localparam logic [ADDR_W-1:0] WORD_MASK = 8'hFC;  // Word-aligned decode

  // Reset values
  localparam logic [CELL_W-1:0] RST_CELL = 8'h00;  // Default of every data cell except the zero-clears flags
  localparam logic [CELL_W-1:0] RST_W0C = 8'hFF;  // Zero-clear flags rest set
  localparam logic [BYP_N-1:0] RST_BYPEN = 4'h0;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;  // Unmapped and undefined reads

  // Hardware side inputs of all cells
  typedef struct packed {
    logic [CELL_W-1:0] ro_val;  // Live value for the read-only cell
    logic [CELL_W-1:0] rc_set;  // Event bits into the read-clear cell
    logic [CELL_W-1:0] w1c_set;  // Event bits into the one-clears cell
    logic [CELL_W-1:0] w0c_set;  // Event bits into the zero-clears cell
    logic [CELL_W-1:0] ros_val;  // Status captured by the sticky read-only cell
    logic ros_load;  // Capture strobe for ros_val
    logic [CELL_W-1:0] readable_set_only_cell_clr;  // Hardware clear of set-only bits
    logic [CELL_W-1:0] w1cs_set;  // Event bits into the sticky one-clears cell
    logic force_we;  // Forced-write strobe for the core read-only cell
    logic [CELL_W-1:0] force_val;
    logic rwv_we;  // Hardware update of the volatile read/write cell
    logic [CELL_W-1:0] rwv_val;
    logic lock;  // Lock from other logic
  } rbac_hw_t;

  // Stored state of all cells, seen by the hardware
  typedef struct packed {
    logic [CELL_W-1:0] rw;
    logic [CELL_W-1:0] rc;
    logic [CELL_W-1:0] w1s;
    logic [CELL_W-1:0] wo;
    logic [CELL_W-1:0] rwo;
    logic [CELL_W-1:0] lock_src;
    logic [BYP_N-1:0] byp_en;
    logic [CELL_W-1:0] rwl;
    logic [CELL_W-1:0] w1c;
    logic [CELL_W-1:0] w0c;
    logic [CELL_W-1:0] sticky_readonly_cell;
    logic [CELL_W-1:0] readable_set_only_cell;
    logic [CELL_W-1:0] sticky_readwrite_cell;
    logic [CELL_W-1:0] w1cs;
    logic [CELL_W-1:0] rwlb;
    logic [CELL_W-1:0] rofw;
    logic [CELL_W-1:0] rwso;
    logic [CELL_W-1:0] rwv;
  } rbac_cells_t;

endpackage : rbac_pkg

/* rbac_top.sv */
// Register bit cell bank: one register per access attribute behind an AXI4-Lite slave
//
// Summary of operation
// - Non-sticky cells return to default on hard reset
// - Read-only returns hardware value, writes ignored
// - Read/write stores and returns software value
// - Read-clear set by hardware, cleared by read
// - Write-one-to-set sets on one, reads undefined
// - Write-only accepts microcode writes, reads undefined
// - Write-once takes one write after reset
// - Lockable cell read-only while lock asserted
// - Lock-source cell drives lock of other fields
// - Written one clears, zero ignored, readable
// - Written zero clears, one ignored, readable
// - Sticky read-only survives hard reset
// - Set-only cell cleared only by hardware
// - Sticky read/write survives hard reset
// - Sticky one-clears survives hard reset
// - Bypass-enabled sources write through active lock
// - Other sources obey lock, read-only
// - Bypass cell sticky, enables are write-once
// - Core writes ignored, forced path updates
// - Sticky write-once keeps value and status
// - Volatile cells also take hardware updates
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps

module rbac_top
  import rbac_pkg::*;
(
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_n_i,  // Power-good reset, returns every cell to its default
  input wire logic hard_rst_n_i,  // Hard reset, returns non-sticky cells to default and clears the bus
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [STRB_W-1:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Hardware side
  input wire rbac_hw_t hw_i,
  output rbac_cells_t cells_o
);

  // Word select of a byte address
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    hit = (addr & WORD_MASK) == ofs;
  endfunction : hit

  // Bit enables of the implemented cell bits from the byte strobes
  function automatic logic [CELL_W-1:0] bit_en(input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < STRB_W; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    bit_en = m[CELL_W-1:0];
  endfunction : bit_en

  // Merge written bits into a stored value under bit enables
  function automatic logic [CELL_W-1:0] merge(input logic [CELL_W-1:0] old, input logic [CELL_W-1:0] wd,
                                              input logic [CELL_W-1:0] be);
    merge = (old & ~be) | (wd & be);
  endfunction : merge

  // Non-sticky state resets on either reset; gating two active-low resets is glitch-safe
  logic any_rst_n;
  assign any_rst_n = rst_n_i & hard_rst_n_i;

  // Bus channel state
  logic aw_rdy_reg;  // Address slot free
  logic w_rdy_reg;  // Data slot free
  logic bvalid_reg;
  logic ar_rdy_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [ADDR_W-1:0] waddr_reg;  // Held write address
  logic [2:0] wprot_reg;  // Held write source
  logic [DATA_W-1:0] wdata_reg;
  logic [STRB_W-1:0] wstrb_reg;

  // Cell storage
  logic [CELL_W-1:0] rw_reg, rc_reg, w1s_reg, wo_reg, rwo_reg, lock_src_reg;
  logic [CELL_W-1:0] rwl_reg, w1c_reg, w0c_reg, ros_reg, readable_set_only_cell_reg, rws_reg;
  logic [CELL_W-1:0] w1cs_reg, rwlb_reg, rofw_reg, rwso_reg, rwv_reg;
  logic [BYP_N-1:0] byp_en_reg;
  logic rwo_done_reg;  // Write-once used since reset
  logic byp_done_reg;  // Bypass enables written
  logic rwso_done_reg;  // Sticky write-once used since power-good

  // Write strobes derived from the held request
  logic wr_fire;  // Both halves held, response slot free
  logic [CELL_W-1:0] be;  // Bit enables
  logic [CELL_W-1:0] wd;  // Write data, cell width
  logic src_priv;  // Microcode or forced-write agent
  logic [GRP_W-1:0] src_grp;  // Bypass group of the writer
  logic lock_active;  // Lock seen by lockable cells
  logic byp_ok;  // Writer may pass the lock
  logic rd_take;  // Read accepted this edge

  assign wr_fire = ~aw_rdy_reg & ~w_rdy_reg & ~bvalid_reg;
  assign be = bit_en(wstrb_reg);
  assign wd = wdata_reg[CELL_W-1:0];
  assign src_priv = wprot_reg[PROT_PRIV_BIT];
  assign src_grp = wprot_reg[GRP_LSB +: GRP_W];
  assign lock_active = lock_src_reg[LOCK_BIT] | hw_i.lock;
  assign byp_ok = byp_en_reg[src_grp];
  assign rd_take = s_axi_arvalid_i & ar_rdy_reg;

  // Write address and data slots; taken in either order, freed by the response
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      aw_rdy_reg <= 1'b1;
      w_rdy_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      waddr_reg <= '0;
      wprot_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      // Address handshake
      if (s_axi_awvalid_i && aw_rdy_reg) begin
        aw_rdy_reg <= 1'b0;
        waddr_reg <= s_axi_awaddr_i;
        wprot_reg <= s_axi_awprot_i;
      end
      // Data handshake
      if (s_axi_wvalid_i && w_rdy_reg) begin
        w_rdy_reg <= 1'b0;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      // Cells update on wr_fire; response follows
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
        aw_rdy_reg <= 1'b1;
        w_rdy_reg <= 1'b1;
      end
    end
  end

  // Read channel; one outstanding read, data registered
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= RD_ZERO;
    end else if (rd_take) begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= RD_ZERO;
      // Reserved upper bits and undefined cells read as zero
      case (1'b1)
        hit(s_axi_araddr_i, OFS_RO): rdata_reg[CELL_W-1:0] <= hw_i.ro_val;
        hit(s_axi_araddr_i, OFS_RW): rdata_reg[CELL_W-1:0] <= rw_reg;
        hit(s_axi_araddr_i, OFS_RC): rdata_reg[CELL_W-1:0] <= rc_reg;
        hit(s_axi_araddr_i, OFS_RWO): rdata_reg[CELL_W-1:0] <= rwo_reg;
        hit(s_axi_araddr_i, OFS_LOCK): rdata_reg[CELL_W-1:0] <= lock_src_reg;
        hit(s_axi_araddr_i, OFS_BYPEN): rdata_reg[BYP_N-1:0] <= byp_en_reg;
        hit(s_axi_araddr_i, OFS_RWL): rdata_reg[CELL_W-1:0] <= rwl_reg;
        hit(s_axi_araddr_i, OFS_W1C): rdata_reg[CELL_W-1:0] <= w1c_reg;
        hit(s_axi_araddr_i, OFS_W0C): rdata_reg[CELL_W-1:0] <= w0c_reg;
        hit(s_axi_araddr_i, OFS_ROS): rdata_reg[CELL_W-1:0] <= ros_reg;
        hit(s_axi_araddr_i, OFS_READABLE_SET_ONLY_CELL): rdata_reg[CELL_W-1:0] <= readable_set_only_cell_reg;
        hit(s_axi_araddr_i, OFS_RWS): rdata_reg[CELL_W-1:0] <= rws_reg;
        hit(s_axi_araddr_i, OFS_W1CS): rdata_reg[CELL_W-1:0] <= w1cs_reg;
        hit(s_axi_araddr_i, OFS_RWLB): rdata_reg[CELL_W-1:0] <= rwlb_reg;
        hit(s_axi_araddr_i, OFS_ROFW): rdata_reg[CELL_W-1:0] <= rofw_reg;
        hit(s_axi_araddr_i, OFS_RWSO): rdata_reg[CELL_W-1:0] <= rwso_reg;
        hit(s_axi_araddr_i, OFS_RWV): rdata_reg[CELL_W-1:0] <= rwv_reg;
        // Write-one-to-set and write-only read as zero
        default: rdata_reg <= RD_ZERO;
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
      ar_rdy_reg <= 1'b1;
    end
  end

  // Plain read/write cell
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rw_reg <= RST_CELL;
    end else if (wr_fire && hit(waddr_reg, OFS_RW)) begin
      rw_reg <= merge(rw_reg, wd, be);
    end
  end

  // Read-clear cell; an event in the clearing cycle survives
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rc_reg <= RST_CELL;
    end else if (rd_take && hit(s_axi_araddr_i, OFS_RC)) begin
      rc_reg <= hw_i.rc_set;
    end else begin
      rc_reg <= rc_reg | hw_i.rc_set;
    end
  end

  // Write-one-to-set and write-only cells; only reset takes the write-one-to-set bits back
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      w1s_reg <= RST_CELL;
      wo_reg <= RST_CELL;
    end else if (wr_fire) begin
      if (hit(waddr_reg, OFS_W1S)) begin
        w1s_reg <= w1s_reg | (wd & be);
      end
      // Core writes to the write-only cell are dropped
      if (hit(waddr_reg, OFS_WO) && src_priv) begin
        wo_reg <= merge(wo_reg, wd, be);
      end
    end
  end

  // Write-once cell; any write with a strobe uses up the single chance
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rwo_reg <= RST_CELL;
      rwo_done_reg <= 1'b0;
    end else if (wr_fire && hit(waddr_reg, OFS_RWO) && !rwo_done_reg && (|wstrb_reg)) begin
      rwo_reg <= merge(rwo_reg, wd, be);
      rwo_done_reg <= 1'b1;
    end
  end

  // Lock source cell; non-sticky, so software must set it again after each reset
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      lock_src_reg <= RST_CELL;
    end else if (wr_fire && hit(waddr_reg, OFS_LOCK) && !hw_i.lock) begin
      lock_src_reg <= merge(lock_src_reg, wd, be);
    end
  end

  // Bypass enables, write-once, one bit per source group
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      byp_en_reg <= RST_BYPEN;
      byp_done_reg <= 1'b0;
    end else if (wr_fire && hit(waddr_reg, OFS_BYPEN) && !byp_done_reg && wstrb_reg[0]) begin
      byp_en_reg <= wd[BYP_N-1:0];
      byp_done_reg <= 1'b1;
    end
  end

  // Lockable cell
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rwl_reg <= RST_CELL;
    end else if (wr_fire && hit(waddr_reg, OFS_RWL) && !lock_active) begin
      rwl_reg <= merge(rwl_reg, wd, be);
    end
  end

  // One-clears and zero-clears flags; hardware set wins over the clear
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      w1c_reg <= RST_CELL;
      w0c_reg <= RST_W0C;
    end else begin
      if (wr_fire && hit(waddr_reg, OFS_W1C)) begin
        w1c_reg <= (w1c_reg & ~(wd & be)) | hw_i.w1c_set;
      end else begin
        w1c_reg <= w1c_reg | hw_i.w1c_set;
      end
      if (wr_fire && hit(waddr_reg, OFS_W0C)) begin
        w0c_reg <= (w0c_reg & ~(~wd & be)) | hw_i.w0c_set;
      end else begin
        w0c_reg <= w0c_reg | hw_i.w0c_set;
      end
    end
  end

  // Set-only cell; hardware clear beats a software set in the same cycle
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      readable_set_only_cell_reg <= RST_CELL;
    end else if (wr_fire && hit(waddr_reg, OFS_READABLE_SET_ONLY_CELL)) begin
      readable_set_only_cell_reg <= (readable_set_only_cell_reg | (wd & be)) & ~hw_i.readable_set_only_cell_clr;
    end else begin
      readable_set_only_cell_reg <= readable_set_only_cell_reg & ~hw_i.readable_set_only_cell_clr;
    end
  end

  // Core read-only forced cell; cores cannot write, forced path can
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rofw_reg <= RST_CELL;
    end else if (hw_i.force_we) begin
      rofw_reg <= hw_i.force_val;
    end else if (wr_fire && hit(waddr_reg, OFS_ROFW) && src_priv) begin
      rofw_reg <= merge(rofw_reg, wd, be);
    end
  end

  // Volatile read/write cell; hardware update wins a collision
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rwv_reg <= RST_CELL;
    end else if (hw_i.rwv_we) begin
      rwv_reg <= hw_i.rwv_val;
    end else if (wr_fire && hit(waddr_reg, OFS_RWV)) begin
      rwv_reg <= merge(rwv_reg, wd, be);
    end
  end

  // Sticky read-only cell, power-good reset only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ros_reg <= RST_CELL;
    end else if (hw_i.ros_load) begin
      ros_reg <= hw_i.ros_val;
    end
  end

  // Sticky read/write cell
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rws_reg <= RST_CELL;
    end else if (wr_fire && hit(waddr_reg, OFS_RWS)) begin
      rws_reg <= merge(rws_reg, wd, be);
    end
  end

  // Sticky one-clears flags; the set wins over the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w1cs_reg <= RST_CELL;
    end else if (wr_fire && hit(waddr_reg, OFS_W1CS)) begin
      w1cs_reg <= (w1cs_reg & ~(wd & be)) | hw_i.w1cs_set;
    end else begin
      w1cs_reg <= w1cs_reg | hw_i.w1cs_set;
    end
  end

  // Bypassable lock cell, sticky; lock and enables are not
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rwlb_reg <= RST_CELL;
    end else if (wr_fire && hit(waddr_reg, OFS_RWLB) && (!lock_active || byp_ok)) begin
      rwlb_reg <= merge(rwlb_reg, wd, be);
    end
  end

  // Sticky write-once; value and used flag both survive hard reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rwso_reg <= RST_CELL;
      rwso_done_reg <= 1'b0;
    end else if (wr_fire && hit(waddr_reg, OFS_RWSO) && !rwso_done_reg && (|wstrb_reg)) begin
      rwso_reg <= merge(rwso_reg, wd, be);
      rwso_done_reg <= 1'b1;
    end
  end

  // Outputs, taken straight from flip-flops except the constant OKAY responses
  assign s_axi_awready_o = aw_rdy_reg;
  assign s_axi_wready_o = w_rdy_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = RESP_OKAY;
  assign s_axi_arready_o = ar_rdy_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = RESP_OKAY;

  // Cell state to the hardware side
  assign cells_o.rw = rw_reg;
  assign cells_o.rc = rc_reg;
  assign cells_o.w1s = w1s_reg;
  assign cells_o.wo = wo_reg;
  assign cells_o.rwo = rwo_reg;
  assign cells_o.lock_src = lock_src_reg;
  assign cells_o.byp_en = byp_en_reg;
  assign cells_o.rwl = rwl_reg;
  assign cells_o.w1c = w1c_reg;
  assign cells_o.w0c = w0c_reg;
  assign cells_o.sticky_readonly_cell = ros_reg;
  assign cells_o.readable_set_only_cell = readable_set_only_cell_reg;
  assign cells_o.sticky_readwrite_cell = rws_reg;
  assign cells_o.w1cs = w1cs_reg;
  assign cells_o.rwlb = rwlb_reg;
  assign cells_o.rofw = rofw_reg;
  assign cells_o.rwso = rwso_reg;
  assign cells_o.rwv = rwv_reg;

endmodule : rbac_top

/* testbench.sv */
// Self-checking bench for the register bit cell bank
`timescale 1ns/1ps
module testbench;
  import rbac_pkg::*;
  // Clock, resets and bus drivers
  logic clk_i = 1'b0, rst_n_i = 1'b0, hard_rst_n_i = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
  logic [DATA_W-1:0] s_axi_wdata_i = 32'h0000_0000;
  logic [STRB_W-1:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  rbac_hw_t hw_i = '0;
  // Design outputs
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [DATA_W-1:0] s_axi_rdata_o;
  rbac_cells_t cells_o;
  int err_total = 0, checks_done = 0;
  rbac_hw_t ev;

  rbac_top dut (.clk_i, .rst_n_i, .hard_rst_n_i, .s_axi_awaddr_i, .s_axi_awprot_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arprot_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .hw_i, .cells_o);

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  task automatic tally_and_finish();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Compare and report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Write one word; address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] p);
    int n;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_awprot_i <= p;
    s_axi_wdata_i <= {24'h00_0000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) break;
    end
    s_axi_bready_i <= 1'b0;
    if (n == 64) begin
      err_total++;
      tally_and_finish();
    end
    chk(s_axi_bresp_o, RESP_OKAY);
  endtask : wr

  // Read one word and compare it
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    int n;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) break;
    end
    s_axi_rready_i <= 1'b0;
    if (n == 64) begin
      err_total++;
      tally_and_finish();
    end
    chk(s_axi_rdata_o, {24'h00_0000, e});
    chk(s_axi_rresp_o, RESP_OKAY);
  endtask : rc

  // One edge of hardware events, then let them land
  task automatic hw_pulse(input rbac_hw_t h);
    @(posedge clk_i);
    hw_i <= h;
    @(posedge clk_i);
    hw_i <= '0;
    @(posedge clk_i);
  endtask : hw_pulse

  // Reset pulse: hard only, or power-good as well
  task automatic pulse_rst(input bit pg);
    @(posedge clk_i);
    hard_rst_n_i <= 1'b0;
    rst_n_i <= !pg;
    repeat (2) @(posedge clk_i);
    hard_rst_n_i <= 1'b1;
    rst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask : pulse_rst

  task automatic t_basic();
    chk(cells_o.w0c, 8'hFF);
    hw_i.ro_val <= 8'h5A;
    wr(OFS_RW, 8'hA5, 3'h0);
    rc(OFS_RW, 8'hA5);
    wr(OFS_RO, 8'hFF, 3'h1);
    rc(OFS_RO, 8'h5A);
    rc(8'h80, 8'h00);
  endtask : t_basic

  task automatic t_events();
    ev = '0;
    ev.rc_set = 8'h05;
    ev.w1c_set = 8'h0F;
    ev.w1cs_set = 8'h30;
    hw_pulse(ev);
    rc(OFS_RC, 8'h05);
    rc(OFS_RC, 8'h00);
    wr(OFS_W1C, 8'h05, 3'h0);
    rc(OFS_W1C, 8'h0A);
    wr(OFS_W0C, 8'hF0, 3'h0);
    rc(OFS_W0C, 8'hF0);
    wr(OFS_W1CS, 8'h10, 3'h0);
    chk(cells_o.w1cs, 8'h20);
    wr(OFS_W1S, 8'h01, 3'h0);
    wr(OFS_W1S, 8'h02, 3'h0);
    wr(OFS_W1S, 8'h00, 3'h0);
    chk(cells_o.w1s, 8'h03);
    wr(OFS_READABLE_SET_ONLY_CELL, 8'h81, 3'h0);
    wr(OFS_READABLE_SET_ONLY_CELL, 8'h00, 3'h0);
    rc(OFS_READABLE_SET_ONLY_CELL, 8'h81);
    ev = '0;
    ev.readable_set_only_cell_clr = 8'h80;
    hw_pulse(ev);
    rc(OFS_READABLE_SET_ONLY_CELL, 8'h01);
  endtask : t_events

  // Core versus privileged sources, forced and hardware updates
  task automatic t_source();
    wr(OFS_WO, 8'h3C, 3'h0);
    chk(cells_o.wo, 8'h00);
    wr(OFS_WO, 8'h3C, 3'h1);
    chk(cells_o.wo, 8'h3C);
    wr(OFS_ROFW, 8'h77, 3'h0);
    chk(cells_o.rofw, 8'h00);
    ev = '0;
    ev.force_we = 1'b1;
    ev.force_val = 8'h77;
    ev.rwv_we = 1'b1;
    ev.rwv_val = 8'hC3;
    hw_pulse(ev);
    chk(cells_o.rofw, 8'h77);
    chk(cells_o.rwv, 8'hC3);
    wr(OFS_RWV, 8'h3C, 3'h0);
    rc(OFS_RWV, 8'h3C);
  endtask : t_source

  task automatic t_lock();
    wr(OFS_RWO, 8'h11, 3'h0);
    wr(OFS_RWO, 8'h22, 3'h0);
    chk(cells_o.rwo, 8'h11);
    wr(OFS_RWSO, 8'h33, 3'h0);
    wr(OFS_RWSO, 8'h44, 3'h0);
    chk(cells_o.rwso, 8'h33);
    wr(OFS_LOCK, 8'h01, 3'h0);
    wr(OFS_RWL, 8'h55, 3'h0);
    chk(cells_o.rwl, 8'h00);
    wr(OFS_BYPEN, 8'h02, 3'h1);
    wr(OFS_BYPEN, 8'h0F, 3'h1);
    chk(cells_o.byp_en, 4'h2);
    wr(OFS_RWLB, 8'h66, 3'h1);
    chk(cells_o.rwlb, 8'h66);
    wr(OFS_RWLB, 8'h99, 3'h2);
    chk(cells_o.rwlb, 8'h66);
    wr(OFS_LOCK, 8'h00, 3'h0);
    wr(OFS_RWL, 8'h5A, 3'h0);
    chk(cells_o.rwl, 8'h5A);
    // Lock from other logic freezes the lock source and the lockable cell
    hw_i.lock <= 1'b1;
    wr(OFS_LOCK, 8'h01, 3'h0);
    chk(cells_o.lock_src, 8'h00);
    wr(OFS_RWL, 8'hA5, 3'h0);
    chk(cells_o.rwl, 8'h5A);
    hw_i.lock <= 1'b0;
  endtask : t_lock

  // Hard reset keeps sticky cells, power-good clears them too
  task automatic t_sticky();
    wr(OFS_RWS, 8'hC3, 3'h0);
    ev = '0;
    ev.ros_load = 1'b1;
    ev.ros_val = 8'h9A;
    hw_pulse(ev);
    pulse_rst(1'b0);
    chk(cells_o.sticky_readwrite_cell, 8'hC3);
    chk(cells_o.sticky_readonly_cell, 8'h9A);
    chk(cells_o.w1cs, 8'h20);
    chk(cells_o.rwlb, 8'h66);
    chk(cells_o.rw, 8'h00);
    chk(cells_o.rwl, 8'h00);
    wr(OFS_RWSO, 8'h55, 3'h0);
    chk(cells_o.rwso, 8'h33);
    wr(OFS_RWO, 8'h12, 3'h0);
    chk(cells_o.rwo, 8'h12);
    wr(OFS_LOCK, 8'h01, 3'h0);
    pulse_rst(1'b1);
    chk(cells_o.sticky_readwrite_cell, 8'h00);
    chk(cells_o.rwso, 8'h00);
    chk(cells_o.sticky_readonly_cell, 8'h00);
  endtask : t_sticky

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    hard_rst_n_i <= 1'b1;
    t_basic();
    t_events();
    t_source();
    t_lock();
    t_sticky();
    tally_and_finish();
  end
endmodule : testbench
